// file: logic/sssrq_top.sv
`timescale 1ns/1ps
`include "sssrq_cfg.svh"
module sssrq_top
  import sssrq_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire sssrq_cmd_t i_command,
  input wire logic [7:0] i_write_data,
  input wire logic [7:0] i_std_event_set,
  input wire logic i_output_queue_read,
  input wire logic i_output_queue_has_msg,
  input wire logic i_error_queue_has_error,
  input wire logic i_measurement_summary,
  input wire logic i_questionable_summary,
  input wire logic i_operation_summary,
  output logic [7:0] o_read_data,
  output logic o_read_valid,
  output logic o_clear_event_sets,
  output logic o_clear_error_queue,
  output logic [7:0] o_status_summary_byte,
  output logic o_master_summary_bit,
  output logic o_service_request
);
  logic [7:0] service_request_mask_reg;
  logic [7:0] service_request_mask_next;
  logic [7:0] std_event_enable_reg;
  logic [7:0] std_event_enable_next;
  logic [7:0] read_data_reg;
  logic [7:0] read_data_next;
  logic read_valid_reg;
  logic read_valid_next;
  logic clear_sets_reg;
  logic clear_sets_next;
  logic [7:0] stb_reg;
  logic [7:0] stb_next;
  logic mss_reg;
  logic mss_next;
  logic srq_reg;
  logic srq_next;
  logic [7:0] std_event_value;
  logic event_summary_bit;
  logic std_event_clear;
  logic [7:0] std_event_set_all;
  logic [7:0] summary_comb;
  logic master_comb;

  function automatic logic [7:0] build_status(input logic meas, input logic err,
      input logic quest, input logic msg, input logic evt, input logic oper);
    logic [7:0] b;
    b = `SSSRQ_RESET_BYTE;
    b[`SSSRQ_SB_MEAS] = meas;
    b[`SSSRQ_SB_ERR] = err;
    b[`SSSRQ_SB_QUEST] = quest;
    b[`SSSRQ_SB_MSG] = msg;
    b[`SSSRQ_SB_EVENT] = evt;
    b[`SSSRQ_SB_OPER] = oper;
    return b;
  endfunction

  // empty-queue read raises the query error flag
  always_comb begin
    std_event_set_all = i_std_event_set & `SSSRQ_SE_MASK;
    if (i_output_queue_read && !i_output_queue_has_msg) begin
      std_event_set_all[`SSSRQ_SE_QUERY] = 1'b1;
    end
    std_event_clear = (i_command == SSSRQ_CMD_CLEAR_STATUS) ||
                      (i_command == SSSRQ_CMD_READ_SER);
  end

  sssrq_event_reg #(
    .WIDTH(8)
  ) u_std_event (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_set(std_event_set_all),
    .i_clear(std_event_clear),
    .i_enable(std_event_enable_reg),
    .o_value(std_event_value),
    .o_summary(event_summary_bit)
  );

  // status byte follows live summaries, no latching
  always_comb begin
    summary_comb = build_status(i_measurement_summary, i_error_queue_has_error,
                                i_questionable_summary, i_output_queue_has_msg,
                                event_summary_bit, i_operation_summary);
    master_comb = |(summary_comb & service_request_mask_reg & `SSSRQ_SRM_MASK);
  end

  // command handling
  always_comb begin
    service_request_mask_next = service_request_mask_reg;
    std_event_enable_next = std_event_enable_reg;
    read_data_next = read_data_reg;
    read_valid_next = 1'b0;
    clear_sets_next = 1'b0;
    unique case (i_command)
      SSSRQ_CMD_NONE: begin
      end
      SSSRQ_CMD_CLEAR_STATUS: begin
        clear_sets_next = 1'b1;
      end
      SSSRQ_CMD_WRITE_SRM: begin
        service_request_mask_next = i_write_data;
      end
      SSSRQ_CMD_READ_SRM: begin
        read_data_next = service_request_mask_reg;
        read_valid_next = 1'b1;
      end
      SSSRQ_CMD_WRITE_SEE: begin
        std_event_enable_next = i_write_data;
      end
      SSSRQ_CMD_READ_SEE: begin
        read_data_next = std_event_enable_reg;
        read_valid_next = 1'b1;
      end
      SSSRQ_CMD_READ_SER: begin
        read_data_next = std_event_value;
        read_valid_next = 1'b1;
      end
      SSSRQ_CMD_READ_STB: begin
        read_data_next = stb_reg;
        read_valid_next = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // registered status outputs, one cycle behind their sources
  always_comb begin
    stb_next = summary_comb;
    stb_next[`SSSRQ_SB_MASTER] = master_comb;
    mss_next = master_comb;
    srq_next = master_comb;
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      service_request_mask_reg <= `SSSRQ_RESET_BYTE;
      std_event_enable_reg <= `SSSRQ_RESET_BYTE;
      read_data_reg <= `SSSRQ_RESET_BYTE;
      read_valid_reg <= 1'b0;
      clear_sets_reg <= 1'b0;
      stb_reg <= `SSSRQ_RESET_BYTE;
      mss_reg <= 1'b0;
      srq_reg <= 1'b0;
    end else begin
      service_request_mask_reg <= service_request_mask_next;
      std_event_enable_reg <= std_event_enable_next;
      read_data_reg <= read_data_next;
      read_valid_reg <= read_valid_next;
      clear_sets_reg <= clear_sets_next;
      stb_reg <= stb_next;
      mss_reg <= mss_next;
      srq_reg <= srq_next;
    end
  end

  assign o_read_data = read_data_reg;
  assign o_read_valid = read_valid_reg;
  assign o_clear_event_sets = clear_sets_reg;
  assign o_clear_error_queue = clear_sets_reg;
  assign o_status_summary_byte = stb_reg;
  assign o_master_summary_bit = mss_reg;
  assign o_service_request = srq_reg;

  a_srm_readback: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command == SSSRQ_CMD_WRITE_SRM ##2 i_command == SSSRQ_CMD_READ_SRM
    |=> o_read_valid && o_read_data == $past(i_write_data, 3))
    else $error("request mask readback wrong");
  a_srm_zero: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command == SSSRQ_CMD_WRITE_SRM && i_write_data == 8'h00
    |=> service_request_mask_reg == 8'h00)
    else $error("mask zero failed");
  a_cls_keeps_mask: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command == SSSRQ_CMD_CLEAR_STATUS
    |=> $stable(service_request_mask_reg) && $stable(std_event_enable_reg)
    && o_clear_error_queue)
    else $error("clear status touched masks");
  a_master_or: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    1'b1 |=> o_master_summary_bit == |($past(summary_comb) & $past(service_request_mask_reg)
    & 8'hbf))
    else $error("master summary wrong");
  a_srq_follows: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    o_service_request == o_master_summary_bit
    && o_status_summary_byte[6] == o_master_summary_bit)
    else $error("request mismatch");
  a_msg_bit: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_output_queue_has_msg |=> o_status_summary_byte[4])
    else $error("message bit lost");
  a_err_bit: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !i_error_queue_has_error |=> !o_status_summary_byte[2])
    else $error("error bit stuck");
  a_query_error: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_output_queue_read && !i_output_queue_has_msg |=> std_event_value[2])
    else $error("query error not flagged");
  a_ser_read_clear: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command == SSSRQ_CMD_READ_SER && std_event_set_all == 8'h00
    |=> std_event_value == 8'h00 ##1 !o_status_summary_byte[5])
    else $error("event summary did not drop");
  a_unused_bit: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !o_status_summary_byte[1])
    else $error("unused status bit set");
  a_read_idle: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command == SSSRQ_CMD_NONE |=> !o_read_valid)
    else $error("read valid without a read");
  a_read_answer: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command inside {SSSRQ_CMD_READ_SRM, SSSRQ_CMD_READ_SEE, SSSRQ_CMD_READ_SER,
    SSSRQ_CMD_READ_STB} |=> o_read_valid)
    else $error("read not answered");
  a_read_hold: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command == SSSRQ_CMD_NONE |=> $stable(o_read_data))
    else $error("read data moved while idle");
  a_stb_read: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command == SSSRQ_CMD_READ_STB |=> o_read_data == $past(o_status_summary_byte))
    else $error("status byte read wrong");
  a_srm_write: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command == SSSRQ_CMD_WRITE_SRM |=> service_request_mask_reg == $past(i_write_data))
    else $error("request mask not stored");
  a_srm_hold: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command != SSSRQ_CMD_WRITE_SRM |=> $stable(service_request_mask_reg))
    else $error("request mask changed unasked");
  a_see_zero: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command == SSSRQ_CMD_WRITE_SEE && i_write_data == 8'h00
    |=> std_event_enable_reg == 8'h00)
    else $error("event enable zero failed");
  a_see_hold: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command != SSSRQ_CMD_WRITE_SEE |=> $stable(std_event_enable_reg))
    else $error("event enable changed unasked");
  a_clear_idle: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_command != SSSRQ_CMD_CLEAR_STATUS |=> !o_clear_event_sets)
    else $error("clear pulse without command");
  a_esb_set: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (std_event_value & std_event_enable_reg) != 8'h00 |=> o_status_summary_byte[5])
    else $error("event summary not set");
  a_esb_block: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (std_event_value & std_event_enable_reg) == 8'h00 |=> !o_status_summary_byte[5])
    else $error("blocked event reached summary");
  a_meas_bit: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    1'b1 |=> o_status_summary_byte[0] == $past(i_measurement_summary))
    else $error("measurement bit wrong");
  a_quest_bit: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    1'b1 |=> o_status_summary_byte[3] == $past(i_questionable_summary))
    else $error("questionable bit wrong");
  a_oper_bit: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    1'b1 |=> o_status_summary_byte[7] == $past(i_operation_summary))
    else $error("operation bit wrong");
  a_msg_clear: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !i_output_queue_has_msg |=> !o_status_summary_byte[4])
    else $error("message bit stuck");
  a_err_set: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_error_queue_has_error |=> o_status_summary_byte[2])
    else $error("error bit lost");
  a_std_unused: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !std_event_value[1])
    else $error("unused event bit set");
  a_mask_bit6: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    1'b1 |=> o_master_summary_bit ==
    |(o_status_summary_byte & $past(service_request_mask_reg) & 8'hbf))
    else $error("master summary disagrees with status byte");
endmodule

// file: logic/sssrq_cfg.svh
`ifndef SSSRQ_CFG_SVH
`define SSSRQ_CFG_SVH
`define SSSRQ_SB_MEAS 0
`define SSSRQ_SB_ERR 2
`define SSSRQ_SB_QUEST 3
`define SSSRQ_SB_MSG 4
`define SSSRQ_SB_EVENT 5
`define SSSRQ_SB_MASTER 6
`define SSSRQ_SB_OPER 7
`define SSSRQ_SE_OPC 0
`define SSSRQ_SE_QUERY 2
`define SSSRQ_SE_DEVICE 3
`define SSSRQ_SE_EXEC 4
`define SSSRQ_SE_CMD 5
`define SSSRQ_SE_USER 6
`define SSSRQ_SE_POWER 7
`define SSSRQ_SRM_MASK 8'hbf
`define SSSRQ_SE_MASK 8'hfd
`define SSSRQ_RESET_BYTE 8'h00
`endif

// file: logic/sssrq_pkg.sv
package sssrq_pkg;
  typedef enum logic [6:0] {
    SSSRQ_CMD_NONE = 7'h00,
    SSSRQ_CMD_CLEAR_STATUS = 7'h01,
    SSSRQ_CMD_WRITE_SRM = 7'h02,
    SSSRQ_CMD_READ_SRM = 7'h04,
    SSSRQ_CMD_WRITE_SEE = 7'h08,
    SSSRQ_CMD_READ_SEE = 7'h10,
    SSSRQ_CMD_READ_SER = 7'h20,
    SSSRQ_CMD_READ_STB = 7'h40
  } sssrq_cmd_t;
endpackage

// file: logic/sssrq_event_reg.sv
`timescale 1ns/1ps
`include "sssrq_cfg.svh"
module sssrq_event_reg #(
  parameter int WIDTH = 8
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_set,
  input wire logic i_clear,
  input wire logic [WIDTH-1:0] i_enable,
  output logic [WIDTH-1:0] o_value,
  output logic o_summary
);
  logic [WIDTH-1:0] value_reg;
  logic [WIDTH-1:0] value_next;

  // new events win over a clear in the same cycle
  always_comb begin
    value_next = i_clear ? i_set : (value_reg | i_set);
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      value_reg <= '0;
    end else begin
      value_reg <= value_next;
    end
  end

  assign o_value = value_reg;
  assign o_summary = |(value_reg & i_enable);

  a_clear_zeroes: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_clear && i_set == '0 |=> value_reg == '0)
    else $error("event clear failed");
  a_summary_mask: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_set & i_enable) != '0 ##1 i_enable == $past(i_enable) |-> o_summary)
    else $error("enabled event lost");
endmodule

// file: tb/sssrq_host_model.sv
`timescale 1ns/1ps
module sssrq_host_model
  import sssrq_pkg::*;
(
  input wire logic i_clock,
  input wire logic [7:0] i_read_data,
  input wire logic i_read_valid,
  output sssrq_cmd_t o_command,
  output logic [7:0] o_write_data
);
  initial begin
    o_command = SSSRQ_CMD_NONE;
    o_write_data = 8'h00;
  end
  // whole mask in one command, data inverted once released
  task automatic send(input sssrq_cmd_t cmd, input logic [7:0] data);
    @(posedge i_clock);
    #1;
    o_command = cmd;
    o_write_data = data;
    @(posedge i_clock);
    #1;
    o_command = SSSRQ_CMD_NONE;
    o_write_data = ~data;
  endtask
  task automatic query(input sssrq_cmd_t cmd, output logic [7:0] data, output logic valid);
    send(cmd, 8'h00);
    data = i_read_data;
    valid = i_read_valid;
  endtask
endmodule

// file: tb/status_summary_srq_logic_bench.sv
`timescale 1ns/1ps
module status_summary_srq_logic_bench;
  import sssrq_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  sssrq_cmd_t command;
  logic [7:0] wdata, std_set, rdata, stb, got;
  logic oq_read, has_msg, has_err, meas, quest, oper, rvalid, clr_ev, clr_eq, master_summary_bit, srq, gv;
  int failures, checks, seed, srm, see, ser, pulses, rnd;
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    if (clr_ev) pulses += 1;
    if (clr_eq) pulses += 16;
  end
  sssrq_top dut_u (.i_clock(clock), .i_reset_n(reset_n), .i_command(command),
    .i_write_data(wdata), .i_std_event_set(std_set), .i_output_queue_read(oq_read),
    .i_output_queue_has_msg(has_msg), .i_error_queue_has_error(has_err),
    .i_measurement_summary(meas), .i_questionable_summary(quest),
    .i_operation_summary(oper), .o_read_data(rdata), .o_read_valid(rvalid),
    .o_clear_event_sets(clr_ev), .o_clear_error_queue(clr_eq),
    .o_status_summary_byte(stb), .o_master_summary_bit(master_summary_bit), .o_service_request(srq));
  sssrq_host_model host_u (.i_clock(clock), .i_read_data(rdata), .i_read_valid(rvalid),
    .o_command(command), .o_write_data(wdata));
  task automatic check_byte(input logic [7:0] g, input logic [7:0] e, input string what);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic check_bit(input logic g, input logic e, input string what);
    check_byte({7'h00, g}, {7'h00, e}, what);
  endtask
  function automatic logic [7:0] exp_stb();
    logic [7:0] sb;
    sb = {oper, 1'b0, |(ser[7:0] & see[7:0]), has_msg, quest, has_err, 1'b0, meas};
    sb[6] = |(sb & srm[7:0]);
    return sb;
  endfunction
  task automatic check_status();
    logic [7:0] e;
    e = exp_stb();
    check_byte(stb, e, "status byte");
    check_bit(master_summary_bit, e[6], "master");
    check_bit(srq, e[6], "request");
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic read_chk(input sssrq_cmd_t cmd, input int e, input string what);
    host_u.query(cmd, got, gv);
    check_bit(gv, 1'b1, "read valid");
    check_byte(got, e[7:0], what);
  endtask
  task automatic pulse_event(input logic [7:0] v);
    std_set = v;
    ser = ser | (v & 8'hfd);
    @(posedge clock);
    #1;
    std_set = 8'h00;
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(25 * 5000);
    failures++;
    complete_run();
  end
  initial begin
    {std_set, oq_read, has_msg, has_err, meas, quest, oper} = '0;
    {failures, checks, srm, see, ser, pulses} = '0;
    seed = 4337;
    repeat (5) @(posedge clock);
    #1;
    reset_n = 1'b1;
    check_byte(stb, 8'h00, "status at reset");
    read_chk(SSSRQ_CMD_READ_SRM, 0, "srm at reset");
    read_chk(SSSRQ_CMD_READ_SEE, 0, "see at reset");
    read_chk(SSSRQ_CMD_READ_SER, 0, "ser at reset");
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      srm = $random(seed) & 8'hbf;
      see = $random(seed) & 8'hfd;
      rnd = $random(seed);
      {meas, quest, oper, has_msg, has_err} = rnd[4:0];
      host_u.send(SSSRQ_CMD_WRITE_SEE, see[7:0]);
      host_u.send(SSSRQ_CMD_WRITE_SRM, srm[7:0]);
      read_chk(SSSRQ_CMD_READ_SRM, srm, "srm");
      rnd = $random(seed);
      pulse_event(rnd[7:0]);
      settle();
      check_status();
      read_chk(SSSRQ_CMD_READ_STB, exp_stb(), "stb read");
      read_chk(SSSRQ_CMD_READ_SEE, see, "see");
      read_chk(SSSRQ_CMD_READ_SER, ser, "ser");
      ser = 0;
      settle();
      check_status();
    end
    $display("test random masks done");
    pulse_event(8'hfd);
    pulses = 0;
    host_u.send(SSSRQ_CMD_CLEAR_STATUS, 8'h00);
    ser = 0;
    settle();
    check_byte(pulses[7:0], 8'h11, "clear pulses");
    read_chk(SSSRQ_CMD_READ_SER, 0, "ser cleared");
    read_chk(SSSRQ_CMD_READ_SRM, srm, "srm kept");
    read_chk(SSSRQ_CMD_READ_SEE, see, "see kept");
    $display("test clear status done");
    host_u.send(SSSRQ_CMD_WRITE_SEE, 8'h00);
    host_u.send(SSSRQ_CMD_WRITE_SRM, 8'h00);
    srm = 0;
    see = 0;
    read_chk(SSSRQ_CMD_READ_SRM, 0, "srm zero");
    read_chk(SSSRQ_CMD_READ_SEE, 0, "see zero");
    settle();
    check_status();
    $display("test zero masks done");
    {has_msg, has_err, meas, quest, oper} = '0;
    see = 8'h04;
    srm = 8'h20;
    host_u.send(SSSRQ_CMD_WRITE_SEE, 8'h04);
    host_u.send(SSSRQ_CMD_WRITE_SRM, 8'h20);
    oq_read = 1'b1;
    ser = 4;
    @(posedge clock);
    #1;
    oq_read = 1'b0;
    settle();
    check_status();
    has_msg = 1'b1;
    oq_read = 1'b1;
    @(posedge clock);
    #1;
    oq_read = 1'b0;
    settle();
    read_chk(SSSRQ_CMD_READ_SER, ser, "query error");
    $display("test query error done");
    complete_run();
  end
endmodule
